// [verilog/sdram_addr_mux_pkg.sv]
`default_nettype none
package sdram_addr_mux_pkg;

   // ==========================================================================
   // Geometry field encodings.
   localparam logic [1:0] BUS_WIDTH_32 = 2'h3;
   localparam logic [1:0] ROW_BITS_12 = 2'h1;
   localparam logic [1:0] ROW_BITS_13 = 2'h2;
   localparam logic [1:0] COL_BITS_10 = 2'h2;
   localparam logic [1:0] COL_BITS_9 = 2'h1;

   // ==========================================================================
   // Register byte offsets on the Wishbone slave.
   localparam logic [3:0] CONFIG_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [3:0] ROW_CAPTURE_OFFSET = 4'h8;
   localparam logic [3:0] COL_CAPTURE_OFFSET = 4'hc;

   // Configuration field positions.
   localparam int BUS_WIDTH_LSB = 0;
   localparam int ROW_BITS_LSB = 2;
   localparam int COL_BITS_LSB = 4;

   // Status field positions.
   localparam int STAT_SUPPORTED_BIT = 0;
   localparam int STAT_GEOM13_BIT = 1;
   localparam int STAT_PHASE_LSB = 2;
   localparam int STAT_REJECT_LSB = 8;

   // Reset values: 32-bit bus, 12 row bits, 10 column bits.
   localparam logic [1:0] BUS_WIDTH_RESET = 2'h3;
   localparam logic [1:0] ROW_BITS_RESET = 2'h1;
   localparam logic [1:0] COL_BITS_RESET = 2'h2;
   localparam logic [17:0] EXT_ADDR_RESET = 18'h00000;
   localparam logic [7:0] REJECT_RESET = 8'h00;

   // ==========================================================================
   // Types.
   typedef struct packed {
      logic [1:0] col_bits;
      logic [1:0] row_bits;
      logic [1:0] bus_width;
   } geom_cfg_t;

   typedef struct packed {
      logic [17:0] addr;
      logic row_strobe_lower_b;
      logic row_strobe_upper_b;
   } ext_pins_t;

   // Gray coded along idle -> row -> column.
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_ROW = 2'b01,
      PH_COL = 2'b11
   } phase_t;

endpackage
`default_nettype wire

// [verilog/sdram_address_mux_32bit.sv]
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// [RL1] The mapping is chosen from the bus width, row width and column width fields.
// [RL2] The 32-bit, 12-row, 10-column mapping serves one 4-bank memory with 10 column bits.
// [RL3] The same mapping serves two 16-bit 4-bank memories side by side.
// [RL4] In the 12/10 row cycle internal A27..A10 drive pins A17..A0 in order.
// [RL5] In the 12/10 column cycle pins carry A17..A0 except A15=A25, A14=A24, A12=precharge.
// [RL6] Bank-select bits are identical in row and column cycles, higher bit on bank input one.
// [RL7] The pin on the memory address/auto-precharge input carries the command's fixed level.
// [RL8] Only the lower row strobe is asserted; the upper row strobe stays deasserted.
// [RL9] The 32-bit, 13-row, 9-column mapping serves one 4-bank memory with 9 column bits.
// [RL10] The same 13/9 mapping serves two 16-bit 4-bank memories side by side.
// [RL11] In 13/9 rows drive A26..A9; columns drive A17..A0 but A16=A25, A15=A24, A12=precharge.
// [RL12] Pins unused by the memory carry plain internal address bits and must not be relied on.

module sdram_address_mux_32bit
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_b,
   // Wishbone classic slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Command side from the controller.
   input wire logic [27:0] int_addr,
   input wire logic row_cmd,
   input wire logic col_cmd,
   input wire logic precharge_level,
   // Memory pins.
   output logic [17:0] ext_addr,
   output logic row_strobe_lower_b,
   output logic row_strobe_upper_b,
   output logic mapping_supported
);

   // ==========================================================================
   // Geometry decode.
   sdram_addr_mux_pkg::geom_cfg_t cfg_q;
   sdram_addr_mux_pkg::geom_cfg_t cfg_d;
   logic geom_12_10;
   logic geom_13_9;
   logic supported;

   always_comb
   begin
      geom_12_10 = (cfg_q.bus_width == sdram_addr_mux_pkg::BUS_WIDTH_32) &&
                   (cfg_q.row_bits == sdram_addr_mux_pkg::ROW_BITS_12) &&
                   (cfg_q.col_bits == sdram_addr_mux_pkg::COL_BITS_10); // [RL1]
      geom_13_9 = (cfg_q.bus_width == sdram_addr_mux_pkg::BUS_WIDTH_32) &&
                  (cfg_q.row_bits == sdram_addr_mux_pkg::ROW_BITS_13) &&
                  (cfg_q.col_bits == sdram_addr_mux_pkg::COL_BITS_9); // [RL1]
      supported = geom_12_10 | geom_13_9;
   end

   // ==========================================================================
   // Command decode.
   // A row command wins over a column command in the same cycle: the column
   // image would otherwise overwrite the row address that the memory latches.
   // Pins are registered, so the memory sees a settled image for a whole
   // cycle; the price is one cycle from command to pin.
   logic take_row;
   logic take_col;
   logic refused;

   always_comb
   begin
      take_row = row_cmd && supported;
      take_col = col_cmd && !row_cmd && supported;
      refused = (row_cmd || col_cmd) && !supported;
   end

   // ==========================================================================
   // Address multiplexer and row strobes.
   // The same pin image serves one x32 device or two x16 devices in parallel,
   // since each x16 part sees the same row, column and bank pins. [RL3] [RL10]
   sdram_addr_mux_pkg::phase_t phase_q;
   sdram_addr_mux_pkg::phase_t phase_d;
   sdram_addr_mux_pkg::ext_pins_t pins_q;
   sdram_addr_mux_pkg::ext_pins_t pins_d;
   logic [17:0] row_cap_q;
   logic [17:0] row_cap_d;
   logic [17:0] col_cap_q;
   logic [17:0] col_cap_d;
   logic [7:0] reject_q;
   logic [7:0] reject_d;

   always_comb
   begin
      phase_d = sdram_addr_mux_pkg::PH_IDLE;
      pins_d = pins_q;
      pins_d.row_strobe_lower_b = 1'b1;
      // The upper strobe is never used: A25 is a bank bit in both settings.
      pins_d.row_strobe_upper_b = 1'b1; // [RL8]
      // A refused command takes neither branch and leaves the last image standing.
      if (take_row)
      begin
         phase_d = sdram_addr_mux_pkg::PH_ROW;
         pins_d.row_strobe_lower_b = 1'b0; // [RL8]
         if (geom_12_10)
         begin
            // 4 banks, 10 column bits; pins A15/A14 carry A25/A24. [RL2] [RL6]
            pins_d.addr = int_addr[27:10]; // [RL4]
         end
         else
         begin
            // 4 banks, 9 column bits; pins A16/A15 carry A25/A24. [RL9] [RL6]
            pins_d.addr = int_addr[26:9]; // [RL11]
         end
      end
      else if (take_col)
      begin
         phase_d = sdram_addr_mux_pkg::PH_COL;
         if (geom_12_10)
         begin
            // A17, A16 and A13 reach no memory pin. [RL12]
            pins_d.addr = {int_addr[17:16], int_addr[25], int_addr[24], int_addr[13],
                           precharge_level, int_addr[11:0]}; // [RL5] [RL6] [RL7]
         end
         else
         begin
            pins_d.addr = {int_addr[17], int_addr[25], int_addr[24], int_addr[14:13],
                           precharge_level, int_addr[11:0]}; // [RL11] [RL6] [RL7] [RL12]
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         phase_q <= sdram_addr_mux_pkg::PH_IDLE;
         pins_q.addr <= sdram_addr_mux_pkg::EXT_ADDR_RESET;
         pins_q.row_strobe_lower_b <= 1'b1;
         pins_q.row_strobe_upper_b <= 1'b1;
      end
      else
      begin
         phase_q <= phase_d;
         pins_q <= pins_d;
      end
   end

   // Last row and column images, kept for software to read back.
   always_comb
   begin
      row_cap_d = row_cap_q;
      col_cap_d = col_cap_q;
      if (take_row)
      begin
         row_cap_d = pins_d.addr;
      end
      if (take_col)
      begin
         col_cap_d = pins_d.addr;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         row_cap_q <= sdram_addr_mux_pkg::EXT_ADDR_RESET;
         col_cap_q <= sdram_addr_mux_pkg::EXT_ADDR_RESET;
      end
      else
      begin
         row_cap_q <= row_cap_d;
         col_cap_q <= col_cap_d;
      end
   end

   // Refused commands are counted so software can spot a controller that runs
   // while an unsupported geometry is set; the count saturates rather than wrapping.
   always_comb
   begin
      reject_d = reject_q;
      if (refused && reject_q != 8'hff)
      begin
         reject_d = reject_q + 8'h01;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         reject_q <= sdram_addr_mux_pkg::REJECT_RESET;
      end
      else
      begin
         reject_q <= reject_d;
      end
   end

   assign ext_addr = pins_q.addr;
   assign row_strobe_lower_b = pins_q.row_strobe_lower_b;
   assign row_strobe_upper_b = pins_q.row_strobe_upper_b;
   assign mapping_supported = supported;

   // ==========================================================================
   // Wishbone slave.
   // Ack follows one cycle after the strobe; a write lands on the edge where
   // the master samples ack, so a held request is applied again on every second edge.
   logic ack_q;
   logic ack_d;
   logic [31:0] dat_q;
   logic [31:0] dat_d;
   logic [31:0] status_word;
   logic [31:0] cfg_word;
   logic [31:0] cfg_wr;

   always_comb
   begin
      status_word = 32'h00000000;
      status_word[sdram_addr_mux_pkg::STAT_SUPPORTED_BIT] = supported;
      status_word[sdram_addr_mux_pkg::STAT_GEOM13_BIT] = geom_13_9;
      status_word[sdram_addr_mux_pkg::STAT_PHASE_LSB +: 2] = phase_q;
      status_word[sdram_addr_mux_pkg::STAT_REJECT_LSB +: 8] = reject_q;
      cfg_word = 32'h00000000;
      cfg_word[sdram_addr_mux_pkg::BUS_WIDTH_LSB +: 2] = cfg_q.bus_width;
      cfg_word[sdram_addr_mux_pkg::ROW_BITS_LSB +: 2] = cfg_q.row_bits;
      cfg_word[sdram_addr_mux_pkg::COL_BITS_LSB +: 2] = cfg_q.col_bits;
      dat_d = dat_q;
      if (cyc_i && stb_i && !ack_q)
      begin
         case (adr_i)
            sdram_addr_mux_pkg::CONFIG_OFFSET: dat_d = cfg_word;
            sdram_addr_mux_pkg::STATUS_OFFSET: dat_d = status_word;
            sdram_addr_mux_pkg::ROW_CAPTURE_OFFSET: dat_d = {14'h0000, row_cap_q};
            sdram_addr_mux_pkg::COL_CAPTURE_OFFSET: dat_d = {14'h0000, col_cap_q};
            default: dat_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         dat_q <= 32'h00000000;
      end
      else
      begin
         dat_q <= dat_d;
      end
   end

   // Ack drops in the cycle after it is given even while the master still
   // holds its strobe, so a held request is answered again every second cycle.
   always_comb
   begin
      ack_d = cyc_i & stb_i & ~ack_q;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= ack_d;
      end
   end

   // Only byte lane zero holds configuration; the other lanes are ignored.
   always_comb
   begin
      cfg_wr = cfg_word;
      if (sel_i[0])
      begin
         cfg_wr[7:0] = dat_i[7:0];
      end
      cfg_d = cfg_q;
      if (cyc_i && stb_i && we_i && ack_q && adr_i == sdram_addr_mux_pkg::CONFIG_OFFSET)
      begin
         cfg_d.bus_width = cfg_wr[sdram_addr_mux_pkg::BUS_WIDTH_LSB +: 2]; // [RL1]
         cfg_d.row_bits = cfg_wr[sdram_addr_mux_pkg::ROW_BITS_LSB +: 2];
         cfg_d.col_bits = cfg_wr[sdram_addr_mux_pkg::COL_BITS_LSB +: 2];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         cfg_q.bus_width <= sdram_addr_mux_pkg::BUS_WIDTH_RESET;
         cfg_q.row_bits <= sdram_addr_mux_pkg::ROW_BITS_RESET;
         cfg_q.col_bits <= sdram_addr_mux_pkg::COL_BITS_RESET;
      end
      else
      begin
         cfg_q <= cfg_d;
      end
   end

   assign ack_o = ack_q;
   assign dat_o = dat_q;

endmodule
`default_nettype wire

// [testbench/sdram_addr_mux_props.sv]
`timescale 1ns/1ns
`default_nettype none
module sdram_addr_mux_props
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_b,
   // Bus and command side.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic [27:0] int_addr,
   input wire logic row_cmd,
   input wire logic col_cmd,
   input wire logic precharge_level,
   // Memory pins.
   input wire logic [17:0] ext_addr,
   input wire logic row_strobe_lower_b,
   input wire logic row_strobe_upper_b,
   input wire logic mapping_supported
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ====================
   // Command mapping.
   sequence s_row;
      row_cmd && mapping_supported;
   endsequence
   sequence s_col;
      col_cmd && !row_cmd && mapping_supported;
   endsequence
   sequence s_ack;
      ack_o ##1 !ack_o;
   endsequence
   AST_ROW_IMAGE: assert property (s_row |=>
      ext_addr == $past(int_addr[27:10]) || ext_addr == $past(int_addr[26:9]))
      else $error("row image wrong");
   AST_COL_IMAGE: assert property (s_col |=>
      {ext_addr[17], ext_addr[13], ext_addr[11:0]}
      == $past({int_addr[17], int_addr[13], int_addr[11:0]}))
      else $error("column image wrong");
   AST_PRECHARGE: assert property (s_col |=> ext_addr[12] == $past(precharge_level))
      else $error("precharge pin wrong");
   AST_BANK: assert property (mapping_supported && (row_cmd || col_cmd) |=>
      ext_addr[15:14] == $past(int_addr[25:24]) || ext_addr[16:15] == $past(int_addr[25:24]))
      else $error("bank pins wrong");
   AST_UPPER_IDLE: assert property (row_strobe_upper_b)
      else $error("upper strobe asserted");
   AST_LOWER: assert property ($past(rst_b) |->
      !row_strobe_lower_b == $past(row_cmd && mapping_supported))
      else $error("lower strobe wrong");
   AST_HOLD: assert property (!(mapping_supported && (row_cmd || col_cmd)) |=>
      $stable(ext_addr))
      else $error("pins moved without command");
   AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> s_ack)
      else $error("ack not one cycle");
endmodule
bind sdram_address_mux_32bit sdram_addr_mux_props u_props (.mclk, .rst_b, .cyc_i, .stb_i,
   .ack_o, .int_addr, .row_cmd, .col_cmd, .precharge_level, .ext_addr, .row_strobe_lower_b,
   .row_strobe_upper_b, .mapping_supported);
`default_nettype wire

// [testbench/sdram_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ====================
// Memory side: latches the bank on each activate.
module sdram_mem_model
(
   // Clock.
   input wire logic mclk,
   // Pins from the mux.
   input wire logic [17:0] pins,
   input wire logic ras_lo_b,
   input wire logic m13,
   // Captured bank.
   output logic [1:0] bank_q
);
   // The bank inputs sit one pin higher in the 13/9 wiring.
   always_ff @(posedge mclk)
   begin
      if (!ras_lo_b)
         bank_q <= m13 ? pins[16:15] : pins[15:14];
   end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic mclk = 1'h0;
   logic rst_b = 1'h0;
   logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, ack_o, lo_b, up_b, supp;
   logic row_cmd = 1'h0, col_cmd = 1'h0, precharge_level = 1'h0, m13 = 1'h0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic [27:0] int_addr = 28'h0;
   logic [17:0] ext_addr, last_row, last_col;
   logic [1:0] bank_q;
   integer seed = 32'h3a5c, n_errors = 0, checked = 0, cycles = 0;
   always #5 mclk = ~mclk;
   sdram_address_mux_32bit dut (.mclk, .rst_b, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .int_addr, .row_cmd, .col_cmd, .precharge_level, .ext_addr,
      .row_strobe_lower_b(lo_b), .row_strobe_upper_b(up_b), .mapping_supported(supp));
   sdram_mem_model mem (.mclk, .pins(ext_addr), .ras_lo_b(lo_b), .m13, .bank_q);
   // ====================
   // Helpers.
   task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task end_sim;
      $display("checked %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_errors++;
         end_sim;
      end
   end
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, 4'hf, d};
      do @(posedge mclk); while (ack_o !== 1'h1);
      rd = dat_o;
      {cyc_i, stb_i} <= 2'h0;
   endtask
   function logic [31:0] cfg(logic m);
      return {26'h0, m ? sdram_addr_mux_pkg::COL_BITS_9 : sdram_addr_mux_pkg::COL_BITS_10,
         m ? sdram_addr_mux_pkg::ROW_BITS_13 : sdram_addr_mux_pkg::ROW_BITS_12, 2'h3};
   endfunction
   function logic [17:0] row_img(logic [27:0] a);
      return m13 ? a[26:9] : a[27:10];
   endfunction
   function logic [17:0] col_img(logic [27:0] a, logic p);
      return m13 ? {a[17], a[25:24], a[14:13], p, a[11:0]}
         : {a[17:16], a[25:24], a[13], p, a[11:0]};
   endfunction
   // A row then a column command back to back; refused ones must leave the pins alone.
   task access(input logic ok);
      logic [27:0] a;
      logic [27:0] b;
      logic p;
      logic [17:0] old;
      a = 28'($random(seed));
      b = 28'($random(seed));
      p = 1'($random(seed));
      old = ext_addr;
      @(posedge mclk);
      row_cmd <= 1'h1;
      int_addr <= a;
      @(posedge mclk);
      {row_cmd, col_cmd, int_addr, precharge_level} <= {2'h1, b, p};
      #1;
      cmp("row pins", 32'(!ok ? old : row_img(a)), 32'(ext_addr));
      cmp("strobes", 32'({1'h1, !ok}), 32'({up_b, lo_b}));
      cmp("supported", 32'(ok), 32'(supp));
      @(posedge mclk);
      col_cmd <= 1'h0;
      #1;
      cmp("col pins", 32'(ok ? col_img(b, p) : old), 32'(ext_addr));
      if (ok)
      begin
         cmp("bank", 32'(a[25:24]), 32'(bank_q));
         last_row = row_img(a);
         last_col = col_img(b, p);
      end
   endtask
   initial
   begin
      repeat (3) @(posedge mclk);
      rst_b <= 1'h1;
      wb(1'h0, sdram_addr_mux_pkg::CONFIG_OFFSET, 32'h0);
      cmp("config reset", cfg(1'h0), rd);
      wb(1'h0, 4'h2, 32'h0);
      cmp("unmapped", 32'h0, rd);
      for (int i = 0; i < 2; i++)
      begin
         m13 <= i[0];
         wb(1'h1, sdram_addr_mux_pkg::CONFIG_OFFSET, cfg(i[0]));
         wb(1'h0, sdram_addr_mux_pkg::STATUS_OFFSET, 32'h0);
         cmp("status", 32'({i[0], 1'h1}), rd);
         repeat (20) access(1'h1);
         wb(1'h0, sdram_addr_mux_pkg::ROW_CAPTURE_OFFSET, 32'h0);
         cmp("row capture", 32'(last_row), rd);
         wb(1'h0, sdram_addr_mux_pkg::COL_CAPTURE_OFFSET, 32'h0);
         cmp("col capture", 32'(last_col), rd);
         $display("test geometry %0d done", i);
      end
      wb(1'h1, sdram_addr_mux_pkg::CONFIG_OFFSET, 32'h25);
      access(1'h0);
      wb(1'h0, sdram_addr_mux_pkg::STATUS_OFFSET, 32'h0);
      cmp("reject status", 32'h200, rd);
      wb(1'h0, sdram_addr_mux_pkg::ROW_CAPTURE_OFFSET, 32'h0);
      cmp("row capture kept", 32'(last_row), rd);
      $display("test unsupported done");
      end_sim;
   end
endmodule
`default_nettype wire
